// [pbm_defs.svh]
`ifndef PBM_DEFS_SVH
`define PBM_DEFS_SVH
// byte count reaches 2^26, so 27 bits; words are 2^24 at most
`define PBM_BYTES_W 27
`define PBM_WORDS_W 25
`define PBM_WORD_BYTES 32'h4
`define PBM_FIFO_AW 4
`define PBM_FIFO_DEPTH 16
`define PBM_OVR_W 16
// pacer base derived from the card clock by a fractional accumulator
`define PBM_CLK_KHZ 125000
`define PBM_BASE_KHZ 4000
`define PBM_FRAC_W 8
`define PBM_FRAC_MOD (`PBM_CLK_KHZ / 1000)
`define PBM_FRAC_STEP (`PBM_BASE_KHZ / 1000)
`define PBM_MODE_PACER 2'h0
`define PBM_MODE_RISE 2'h1
`define PBM_MODE_FALL 2'h2
`define PBM_MODE_HSHK 2'h3
`endif

// [pbm_pkg.sv]
package pbm_pkg;
  typedef enum logic [1:0] {
    PBM_IDLE = 2'b00,
    PBM_ARM = 2'b01,
    PBM_RUN = 2'b10
  } pbm_state_type;
endpackage : pbm_pkg

// [pbm_dma.sv]
`timescale 1ns/1ps
`include "pbm_defs.svh"
module pbm_dma (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic [1:0] sample_mode_in,
  input wire logic start_on_edge_in,
  input wire logic edge_down_in,
  input wire logic flush_buffer_on_start_in,
  input wire logic stop_input_on_done_in,
  input wire logic twin_half_enable_in,
  input wire logic irq_enable_in,
  input wire logic [`PBM_BYTES_W-1:0] byte_count_in,
  input wire logic [31:0] start_addr_in,
  input wire logic [15:0] pacer_divider_a_in,
  input wire logic [15:0] pacer_divider_b_in,
  input wire logic pacer_cascade_in,
  input wire logic half_clear_in,
  input wire logic [31:0] input_data_in,
  input wire logic input_request_in,
  input wire logic start_trigger_in,
  input wire logic mem_gnt_in,
  output logic input_acknowledge_out,
  output logic mem_req_out,
  output logic [31:0] mem_addr_out,
  output logic [31:0] mem_data_out,
  output logic transfer_running_out,
  output logic transfer_done_out,
  output logic done_irq_out,
  output logic half_filled_flag_out,
  output logic [`PBM_WORDS_W-1:0] samples_done_out,
  output logic [`PBM_OVR_W-1:0] overrun_count_out
);
  ////////////////////////////////////////////////////////////////////
  pbm_pkg::pbm_state_type state_ff, nxt_state;
  logic [31:0] din_s1_ff, din_s2_ff, hold_ff;
  logic rq_s1_ff, rq_s2_ff, rq_s3_ff, tg_s1_ff, tg_s2_ff, tg_s3_ff;
  logic sample_on_ff, pend_ff, ack_ff, done_ff, irq_ff, half_ff, run_ff;
  logic [`PBM_FRAC_W-1:0] frac_ff;
  logic [15:0] div_a_ff, div_b_ff;
  logic [31:0] fifo_mem [0:`PBM_FIFO_DEPTH-1];
  logic [`PBM_FIFO_AW:0] wr_ptr_ff, rd_ptr_ff;
  logic req_ff;
  logic [31:0] addr_ff, data_ff, waddr_ff;
  logic [`PBM_WORDS_W-1:0] total_ff, iss_left_ff, acc_ff, pos_ff;
  logic [`PBM_OVR_W-1:0] ovr_ff;
  ////////////////////////////////////////////////////////////////////
  // pin inputs pass two flops; stage three only feeds edge detection
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      din_s1_ff <= 32'h0;
      din_s2_ff <= 32'h0;
      {rq_s1_ff, rq_s2_ff, rq_s3_ff} <= 3'h0;
      {tg_s1_ff, tg_s2_ff, tg_s3_ff} <= 3'h0;
    end
    else
    begin
      din_s1_ff <= input_data_in;
      din_s2_ff <= din_s1_ff;
      {rq_s1_ff, rq_s2_ff, rq_s3_ff} <= {input_request_in, rq_s1_ff, rq_s2_ff};
      {tg_s1_ff, tg_s2_ff, tg_s3_ff} <= {start_trigger_in, tg_s1_ff, tg_s2_ff};
    end
  end
  ////////////////////////////////////////////////////////////////////
  // pacer: 4 MHz base ticks, then divider a, optionally divider b
  wire [`PBM_FRAC_W-1:0] frac_sum = frac_ff + `PBM_FRAC_W'(`PBM_FRAC_STEP);
  wire base_tick = frac_sum >= `PBM_FRAC_W'(`PBM_FRAC_MOD);
  wire a_wrap = base_tick && (div_a_ff >= pacer_divider_a_in - 16'h1);
  wire b_wrap = a_wrap && (div_b_ff >= pacer_divider_b_in - 16'h1);
  wire pacer_tick = pacer_cascade_in ? b_wrap : a_wrap;
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      frac_ff <= `PBM_FRAC_W'h0;
      div_a_ff <= 16'h0;
      div_b_ff <= 16'h0;
    end
    else
    begin
      frac_ff <= base_tick ? frac_sum - `PBM_FRAC_W'(`PBM_FRAC_MOD) : frac_sum;
      if (base_tick)
        div_a_ff <= a_wrap ? 16'h0 : div_a_ff + 16'h1;
      if (a_wrap)
        div_b_ff <= b_wrap ? 16'h0 : div_b_ff + 16'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // fifo between sampling and bus master
  wire [`PBM_FIFO_AW:0] fifo_lvl = wr_ptr_ff - rd_ptr_ff;
  wire fifo_empty = fifo_lvl == '0;
  wire fifo_full = fifo_lvl == (`PBM_FIFO_AW+1)'(`PBM_FIFO_DEPTH);
  wire flush_now = start_in && flush_buffer_on_start_in;
  wire fifo_wr = pend_ff && !fifo_full && !flush_now;
  wire rq_rise = rq_s2_ff && !rq_s3_ff;
  wire rq_fall = !rq_s2_ff && rq_s3_ff;
  wire hs_take = rq_s2_ff && !ack_ff && !pend_ff;
  wire sample_evt = sample_on_ff && !pend_ff &&
    ((sample_mode_in == `PBM_MODE_PACER) ? pacer_tick :
     (sample_mode_in == `PBM_MODE_RISE) ? rq_rise :
     (sample_mode_in == `PBM_MODE_FALL) ? rq_fall : hs_take);
  // a stalled sample holds its word rather than being lost
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pend_ff <= 1'b0;
      hold_ff <= 32'h0;
      ack_ff <= 1'b0;
    end
    else
    begin
      if (sample_evt)
      begin
        pend_ff <= 1'b1;
        hold_ff <= din_s2_ff;
      end
      else if (fifo_wr || flush_now)
        pend_ff <= 1'b0;
      if (sample_evt && sample_mode_in == `PBM_MODE_HSHK)
        ack_ff <= 1'b1;
      else if (!rq_s2_ff)
        ack_ff <= 1'b0;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (fifo_wr)
      fifo_mem[wr_ptr_ff[`PBM_FIFO_AW-1:0]] <= hold_ff;
  end
  ////////////////////////////////////////////////////////////////////
  // bus master: one word per beat, request dropped when fifo runs dry
  wire running = state_ff != pbm_pkg::PBM_IDLE;
  wire can_issue = (state_ff == pbm_pkg::PBM_RUN) && !fifo_empty &&
    (iss_left_ff != '0) && (!req_ff || mem_gnt_in);
  wire beat = req_ff && mem_gnt_in;
  wire last_iss = iss_left_ff == `PBM_WORDS_W'h1;
  wire [`PBM_WORDS_W-1:0] acc_nxt = acc_ff + `PBM_WORDS_W'h1;
  wire [`PBM_WORDS_W-1:0] pos_nxt = pos_ff + `PBM_WORDS_W'h1;
  wire ring_end = pos_nxt == total_ff;
  wire half_hit = twin_half_enable_in && beat &&
    ((pos_nxt == (total_ff >> 1)) || ring_end);
  wire finish = beat && !twin_half_enable_in && acc_nxt == total_ff;
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rd_ptr_ff <= '0;
      wr_ptr_ff <= '0;
      req_ff <= 1'b0;
      addr_ff <= 32'h0;
      waddr_ff <= 32'h0;
      data_ff <= 32'h0;
      iss_left_ff <= '0;
    end
    else
    begin
      if (fifo_wr)
        wr_ptr_ff <= wr_ptr_ff + (`PBM_FIFO_AW+1)'(1);
      if (flush_now)
        rd_ptr_ff <= wr_ptr_ff;
      else if (can_issue)
        rd_ptr_ff <= rd_ptr_ff + (`PBM_FIFO_AW+1)'(1);
      if (start_in || stop_in || finish)
        req_ff <= 1'b0;
      else if (can_issue)
        req_ff <= 1'b1;
      else if (beat)
        req_ff <= 1'b0;
      // next address kept apart so word zero lands on the start address
      if (start_in)
      begin
        waddr_ff <= start_addr_in;
        iss_left_ff <= byte_count_in[`PBM_BYTES_W-1:2];
      end
      else if (can_issue)
      begin
        data_ff <= fifo_mem[rd_ptr_ff[`PBM_FIFO_AW-1:0]];
        addr_ff <= waddr_ff;
        waddr_ff <= waddr_ff + `PBM_WORD_BYTES;
        iss_left_ff <= iss_left_ff - `PBM_WORDS_W'h1;
        if (twin_half_enable_in && last_iss)
        begin
          waddr_ff <= start_addr_in;
          iss_left_ff <= total_ff;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // control state, counts and completion
  wire trig_seen = edge_down_in ? (!tg_s2_ff && tg_s3_ff) : (tg_s2_ff && !tg_s3_ff);
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      pbm_pkg::PBM_IDLE:
        if (start_in)
          nxt_state = start_on_edge_in ? pbm_pkg::PBM_ARM : pbm_pkg::PBM_RUN;
      pbm_pkg::PBM_ARM:
        if (stop_in)
          nxt_state = pbm_pkg::PBM_IDLE;
        else if (trig_seen)
          nxt_state = pbm_pkg::PBM_RUN;
      pbm_pkg::PBM_RUN:
        if (stop_in || finish)
          nxt_state = pbm_pkg::PBM_IDLE;
      default:
        nxt_state = pbm_pkg::PBM_IDLE;
    endcase
  end
  wire arm_go = state_ff == pbm_pkg::PBM_ARM && nxt_state == pbm_pkg::PBM_RUN;
  wire go_now = start_in && !start_on_edge_in;
  wire nxt_running = nxt_state != pbm_pkg::PBM_IDLE;
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_ff <= pbm_pkg::PBM_IDLE;
      sample_on_ff <= 1'b0;
      run_ff <= 1'b0;
      total_ff <= '0;
      acc_ff <= '0;
      pos_ff <= '0;
      done_ff <= 1'b0;
      irq_ff <= 1'b0;
      half_ff <= 1'b0;
      ovr_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      run_ff <= nxt_running;
      if (go_now || arm_go)
        sample_on_ff <= 1'b1;
      else if (stop_in || start_in || (finish && stop_input_on_done_in))
        sample_on_ff <= 1'b0;
      done_ff <= finish;
      irq_ff <= finish && irq_enable_in;
      if (start_in)
      begin
        total_ff <= byte_count_in[`PBM_BYTES_W-1:2];
        acc_ff <= '0;
        pos_ff <= '0;
        half_ff <= 1'b0;
        ovr_ff <= '0;
      end
      else
      begin
        if (beat && running)
        begin
          acc_ff <= acc_nxt;
          pos_ff <= ring_end ? '0 : pos_nxt;
        end
        // set wins over a clear in the same cycle
        if (half_hit && running)
          half_ff <= 1'b1;
        else if (half_clear_in)
          half_ff <= 1'b0;
        if (half_hit && running && half_ff && !half_clear_in)
          ovr_ff <= ovr_ff + `PBM_OVR_W'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  assign input_acknowledge_out = ack_ff;
  assign mem_req_out = req_ff;
  assign mem_addr_out = addr_ff;
  assign mem_data_out = data_ff;
  assign transfer_running_out = run_ff;
  assign transfer_done_out = done_ff;
  assign done_irq_out = irq_ff;
  assign half_filled_flag_out = half_ff;
  assign samples_done_out = acc_ff;
  assign overrun_count_out = ovr_ff;
  ////////////////////////////////////////////////////////////////////
  sequence s_last_beat;
    beat && !twin_half_enable_in && acc_nxt == total_ff;
  endsequence
  sequence s_quiet;
    !transfer_running_out && transfer_done_out;
  endsequence
  property p_end_exact;
    @(posedge clk_in) disable iff (sys_rst_in)
    $rose(transfer_done_out) |-> acc_ff == total_ff;
  endproperty
  a_end_exact: assert property (p_end_exact) else $error("block ended early");
  property p_done_status;
    @(posedge clk_in) disable iff (sys_rst_in)
    s_last_beat and !start_in |=> s_quiet;
  endproperty
  a_done_status: assert property (p_done_status) else $error("status not stopped");
  property p_irq;
    @(posedge clk_in) disable iff (sys_rst_in)
    done_irq_out |-> transfer_done_out && $past(irq_enable_in);
  endproperty
  a_irq: assert property (p_irq) else $error("stray interrupt");
  property p_no_full_write;
    @(posedge clk_in) disable iff (sys_rst_in)
    fifo_full |=> fifo_lvl <= $past(fifo_lvl);
  endproperty
  a_no_full_write: assert property (p_no_full_write) else $error("fifo overfilled");
  property p_addr_step;
    @(posedge clk_in) disable iff (sys_rst_in)
    can_issue && !start_in && !last_iss |=> waddr_ff == mem_addr_out + 32'h4;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address not word step");
  property p_release;
    @(posedge clk_in) disable iff (sys_rst_in)
    fifo_empty && (!req_ff || beat) |=> !mem_req_out;
  endproperty
  a_release: assert property (p_release) else $error("bus held while empty");
  property p_ack;
    @(posedge clk_in) disable iff (sys_rst_in)
    $rose(input_acknowledge_out) |-> $past(rq_s2_ff) && sample_mode_in == `PBM_MODE_HSHK;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge without request");
  property p_wait_trig;
    @(posedge clk_in) disable iff (sys_rst_in)
    state_ff == pbm_pkg::PBM_ARM && !trig_seen |=> !sample_on_ff;
  endproperty
  a_wait_trig: assert property (p_wait_trig) else $error("sampled before trigger");
  property p_half_twin;
    @(posedge clk_in) disable iff (sys_rst_in)
    $rose(half_filled_flag_out) |-> twin_half_enable_in;
  endproperty
  a_half_twin: assert property (p_half_twin) else $error("half flag in single mode");
  property p_flush;
    @(posedge clk_in) disable iff (sys_rst_in)
    flush_now |=> fifo_empty;
  endproperty
  a_flush: assert property (p_flush) else $error("fifo not flushed");
endmodule : pbm_dma

// [pbm_far_model.sv]
`timescale 1ns/1ps
module pbm_far_model (
  input wire logic clk_in,
  input wire logic [1:0] mode_in,
  input wire logic gnt_hold_in,
  input wire logic input_acknowledge_in,
  output logic [31:0] input_data_out,
  output logic input_request_out,
  output logic mem_gnt_out
);
  initial
  begin
    input_data_out = 32'h0;
    input_request_out = 1'b0;
    mem_gnt_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // memory stalls at random, and fully while held off
  always @(posedge clk_in)
  begin
    #1;
    mem_gnt_out = !gnt_hold_in && ($urandom_range(3) != 0);
  end
  ////////////////////////////////////////////////////////////
  task automatic send_one(input logic [31:0] w);
    int n;
    begin
      @(posedge clk_in);
      #1;
      input_data_out = w;
      // pacer source drives its port continuously; request parked low
      if (mode_in == 2'h0)
      begin
        input_request_out = 1'b0;
        return;
      end
      input_request_out = (mode_in == 2'h2);
      repeat (4) @(posedge clk_in);
      #1;
      input_request_out = !input_request_out;
      if (mode_in == 2'h3)
      begin
        for (n = 0; n < 3000 && input_acknowledge_in !== 1'b1; n++)
        begin
          @(posedge clk_in);
          #1;
        end
        input_request_out = 1'b0;
        for (n = 0; n < 3000 && input_acknowledge_in !== 1'b0; n++)
        begin
          @(posedge clk_in);
          #1;
        end
      end
      else
      begin
        repeat (6) @(posedge clk_in);
        #1;
        input_request_out = !input_request_out;
        repeat (3) @(posedge clk_in);
      end
      @(posedge clk_in);
      #1;
      // released data no longer shows the sample
      input_data_out = ~w;
    end
  endtask : send_one
endmodule : pbm_far_model

// [parallel_input_bus_master_dma_tb.sv]
`timescale 1ns/1ps
`include "pbm_defs.svh"
module parallel_input_bus_master_dma_tb;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic start_in = 1'b0, stop_in = 1'b0, start_on_edge_in = 1'b0, edge_down_in = 1'b0;
  logic flush_buffer_on_start_in = 1'b0, stop_input_on_done_in = 1'b0, gnt_hold = 1'b0;
  logic twin_half_enable_in = 1'b0, irq_enable_in = 1'b0, pacer_cascade_in = 1'b0;
  logic half_clear_in = 1'b0, start_trigger_in = 1'b1;
  logic [1:0] sample_mode_in = 2'h3;
  logic [`PBM_BYTES_W-1:0] byte_count_in = '0;
  logic [31:0] start_addr_in = 32'h0;
  logic [15:0] pacer_divider_a_in = 16'h2;
  logic [15:0] pacer_divider_b_in = 16'h2;
  logic [31:0] input_data_in, mem_addr_out, mem_data_out, e, w;
  logic input_request_in, mem_gnt_in, input_acknowledge_out, mem_req_out;
  logic transfer_running_out, transfer_done_out, done_irq_out, half_filled_flag_out;
  logic [`PBM_WORDS_W-1:0] samples_done_out;
  logic [`PBM_OVR_W-1:0] overrun_count_out;
  logic [31:0] q[$];
  logic [31:0] pace_word = 32'h0;
  int fails = 0, check_count = 0, cyc = 0, beats = 0, dones = 0, irqs = 0, ring = 1;
  localparam logic [31:0] BASE = 32'h0000_4000;
  pbm_dma i_dut (.clk_in, .sys_rst_in, .start_in, .stop_in, .sample_mode_in,
    .start_on_edge_in, .edge_down_in, .flush_buffer_on_start_in, .stop_input_on_done_in,
    .twin_half_enable_in, .irq_enable_in, .byte_count_in, .start_addr_in,
    .pacer_divider_a_in, .pacer_divider_b_in, .pacer_cascade_in, .half_clear_in,
    .input_data_in, .input_request_in, .start_trigger_in, .mem_gnt_in,
    .input_acknowledge_out, .mem_req_out, .mem_addr_out, .mem_data_out,
    .transfer_running_out, .transfer_done_out, .done_irq_out, .half_filled_flag_out,
    .samples_done_out, .overrun_count_out);
  pbm_far_model i_far (.clk_in, .mode_in(sample_mode_in), .gnt_hold_in(gnt_hold),
    .input_acknowledge_in(input_acknowledge_out), .input_data_out(input_data_in),
    .input_request_out(input_request_in), .mem_gnt_out(mem_gnt_in));
  always #4 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      check_count++;
      if (seen !== exp)
      begin
        fails++;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask : check
  task automatic end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask : end_sim
  task automatic tick(input int n);
    begin
      repeat (n) @(posedge clk_in);
      #1;
    end
  endtask : tick
  task automatic pulse_stop;
    begin
      stop_in = 1'b1;
      tick(1);
      stop_in = 1'b0;
      tick(4);
    end
  endtask : pulse_stop
  task automatic run(input logic [1:0] m, input int n, input logic fl, input logic sod,
    input logic tw);
    begin
      tick(1);
      sample_mode_in = m;
      flush_buffer_on_start_in = fl;
      stop_input_on_done_in = sod;
      twin_half_enable_in = tw;
      byte_count_in = `PBM_BYTES_W'(n * 4);
      start_addr_in = BASE;
      beats = 0;
      dones = 0;
      irqs = 0;
      ring = n;
      if (fl)
        q.delete();
      start_in = 1'b1;
      tick(1);
      start_in = 1'b0;
    end
  endtask : run
  task automatic send(input int n);
    begin
      repeat (n)
      begin
        w = $urandom;
        q.push_back(w);
        i_far.send_one(w);
      end
    end
  endtask : send
  task automatic fin(input int n);
    int k;
    begin
      for (k = 0; k < 5000 && dones == 0; k++) tick(1);
      tick(20);
      check(beats, n);
      check(dones, 1);
      check(irqs, 32'(irq_enable_in));
      check(32'(transfer_running_out), 32'h0);
      check(32'(samples_done_out), n);
    end
  endtask : fin
  ////////////////////////////////////////////////////////////
  // model: queue of sent words, address walks the ring
  always @(posedge clk_in)
  begin
    cyc++;
    if (mem_req_out === 1'b1 && mem_gnt_in === 1'b1)
    begin
      e = (q.size() != 0) ? q.pop_front() : pace_word;
      check(mem_data_out, e);
      check(mem_addr_out, BASE + 32'(4 * (beats % ring)));
      beats++;
    end
    if (transfer_done_out === 1'b1)
      dones++;
    if (done_irq_out === 1'b1)
      irqs++;
    if (cyc == 30000)
    begin
      fails++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(32'hc150));
    tick(16);
    sys_rst_in = 1'b0;
    // memory held off so the fifo fills and the source stalls
    irq_enable_in = 1'b1;
    run(2'h3, 20, 1'b1, 1'b1, 1'b0);
    gnt_hold = 1'b1;
    fork
      begin
        tick(300);
        gnt_hold = 1'b0;
      end
    join_none
    send(20);
    fin(20);
    // extra words stay behind, then drain without flush
    irq_enable_in = 1'b0;
    run(2'h1, 4, 1'b1, 1'b0, 1'b0);
    send(6);
    fin(4);
    run(2'h1, 2, 1'b0, 1'b1, 1'b0);
    fin(2);
    run(2'h2, 3, 1'b1, 1'b1, 1'b0);
    send(5);
    fin(3);
    q.delete();
    run(2'h2, 2, 1'b0, 1'b1, 1'b0);
    send(2);
    fin(2);
    // pacer held until a falling trigger
    pace_word = $urandom;
    sample_mode_in = 2'h0;
    i_far.send_one(pace_word);
    start_on_edge_in = 1'b1;
    edge_down_in = 1'b1;
    run(2'h0, 4, 1'b1, 1'b1, 1'b0);
    tick(300);
    check(beats, 0);
    check(32'(transfer_running_out), 32'h1);
    start_trigger_in = 1'b0;
    fin(4);
    start_on_edge_in = 1'b0;
    pacer_cascade_in = 1'b1;
    run(2'h0, 64, 1'b1, 1'b1, 1'b0);
    tick(700);
    pulse_stop();
    check(32'(transfer_running_out), 32'h0);
    check(dones, 0);
    check(32'(samples_done_out), beats);
    check(32'(beats >= 4 && beats <= 6), 32'h1);
    // ring of 8 filled twice with no half read
    run(2'h3, 8, 1'b1, 1'b0, 1'b1);
    send(16);
    tick(20);
    check(32'(half_filled_flag_out), 32'h1);
    check(32'(overrun_count_out), 32'h3);
    check(dones, 0);
    half_clear_in = 1'b1;
    tick(1);
    half_clear_in = 1'b0;
    tick(2);
    check(32'(half_filled_flag_out), 32'h0);
    pulse_stop();
    end_sim();
  end
endmodule : parallel_input_bus_master_dma_tb
